//--- src/mbtc_pkg.sv
// Purpose: Constants shared by the block transfer channel files.
// Assumes: 100 MHz clock, 16 device controllers, 16-bit words.
// Notes: Mode bits sit at the top of the count/mode word.
package mbtc_pkg;
    localparam int NDEV = 16;
    localparam int IDXW = 4;
    localparam int LENW = 13;
    localparam int DIR_BIT = 15;
    localparam int BURST_BIT = 14;
    localparam int WORD_BIT = 13;
    localparam logic [7:0] CW_BASE = 8'h00;
    localparam logic [7:0] STAT_OFF = 8'h80;
    localparam logic [15:0] CW_RST = 16'h0000;
    localparam int CLK_NS = 10;
    localparam int US_NS = 1000;
    localparam int TICK_CYC = US_NS / CLK_NS;
    localparam int NORM_US = 5;
    localparam int BURST_US = 3;
    localparam int STOP_US = 25;
    localparam int TICK_LEAD = 2;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_READ = 3'b001,
        S_IO = 3'b010,
        S_WRITE = 3'b011,
        S_PAD = 3'b100
    } mbtc_st_type;
endpackage

//--- src/mbtc_arb_if.sv
// Purpose: Request and grant between engine and priority arbiter.
// Assumes: Index 0 has the highest priority.
// Notes: Grant is combinational from the request vector.
`timescale 1ns/1ns
`default_nettype none
interface mbtc_arb_if;
    logic [15:0] req;
    logic valid;
    logic [3:0] idx;
    modport arb (input req, output valid, output idx);
    modport user (output req, input valid, input idx);
endinterface
`default_nettype wire

//--- src/mbtc_arb.sv
// Purpose: Fixed priority pick among pending service requests.
// Assumes: Requests are already synchronised.
// Notes: No state, so no reset.
`timescale 1ns/1ns
`default_nettype none
module mbtc_arb (
    // Request and grant
    mbtc_arb_if.arb a
);
    always_comb begin
        a.valid = |a.req;
        a.idx = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (a.req[i]) begin
                a.idx = 4'(i);
            end
        end
    end
endmodule
`default_nettype wire

//--- src/mbtc_tick.sv
// Purpose: One microsecond enable pulse, restartable.
// Assumes: clr_i restarts the period with a short lead so a service spans whole steps.
// Notes: The pulse is one clock wide.
`timescale 1ns/1ns
`default_nettype none
module mbtc_tick (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic clr_i,
    output logic tick_o
);
    import mbtc_pkg::*;
    typedef struct packed {
        logic [6:0] cnt;
        logic tick;
    } mbtc_tick_type;
    mbtc_tick_type s, next_s;
    // A restart preloads the lead, which covers the two cycles from the last step to the next start.
    always_comb begin
        next_s.tick = !clr_i && s.cnt == 7'(TICK_CYC - 1);
        if (clr_i) begin
            next_s.cnt = 7'(TICK_LEAD);
        end else if (next_s.tick) begin
            next_s.cnt = 7'h00;
        end else begin
            next_s.cnt = s.cnt + 7'h01;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
    assign tick_o = s.tick;
endmodule
`default_nettype wire

//--- src/mbtc_chan.sv
// Purpose: Multiplexed block transfer channel for 16 device controllers.
// Assumes: Control words live in a local page reached over Wishbone.
// Notes: Data words move over a simple memory master port.
`timescale 1ns/1ns
`default_nettype none
module mbtc_chan (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Data memory master
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [15:0] mem_adr_o,
    output logic [15:0] mem_dat_o,
    input wire logic [15:0] mem_dat_i,
    input wire logic mem_ack_i,
    // Processor
    input wire logic idle_i,
    output logic hold_o,
    output logic [mbtc_pkg::NDEV-1:0] level_irq_o,
    output logic stop_ok_o,
    // Shared I/O bus
    input wire logic [mbtc_pkg::NDEV-1:0] srq_i,
    input wire logic io_ack_i,
    input wire logic [15:0] io_dat_i,
    output logic io_stb_o,
    output logic io_dir_o,
    output logic [3:0] io_sel_o,
    output logic [15:0] io_dat_o
);
    import mbtc_pkg::*;

    typedef struct packed {
        mbtc_st_type st;
        logic [3:0] idx;
        logic [2:0] step;
        logic [15:0] cw1;
        logic [15:0] cw2;
        logic [15:0] data;
        logic acked;
        logic held;
        logic [3:0] held_idx;
        logic [15:0] hcw1;
        logic [15:0] hcw2;
        logic [31:0][15:0] page;
        logic [2:0][15:0] srq_s;
        logic [2:0] ack_s;
        logic [2:0][15:0] din_s;
        logic [15:0] srq;
        logic ack;
        logic [4:0] quiet_cnt;
        logic quiet;
        logic wb_ack;
        logic [15:0] wb_dat;
        logic mem_req;
        logic mem_we;
        logic [15:0] mem_adr;
        logic [15:0] mem_dat;
        logic io_stb;
        logic io_dir;
        logic [3:0] io_sel;
        logic [15:0] io_dat;
        logic [15:0] irq;
        logic hold;
    } mbtc_chan_type;

    mbtc_chan_type s, next_s;
    mbtc_arb_if arb_bus ();
    logic tick;
    logic start;
    logic zero;
    logic eng_wr;
    logic [2:0] lim;
    logic [15:0] w1;
    logic [15:0] w2;
    logic [15:0] ncw1;
    logic [15:0] ncw2;
    logic [15:0] merged;
    logic done;

    mbtc_arb u_arb (
        .a(arb_bus)
    );

    mbtc_tick u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(start),
        .tick_o(tick)
    );

    // Only synchronised, settled requests reach the arbiter.
    assign arb_bus.req = s.srq;

    function automatic logic [2:0] steps_of(input logic [15:0] cw);
        steps_of = cw[BURST_BIT] ? 3'(BURST_US) : 3'(NORM_US);
    endfunction

    always_comb begin
        next_s = s;
        start = 1'b0;
        eng_wr = 1'b0;
        done = 1'b0;
        lim = steps_of(s.cw2);
        // A burst controller uses its held words, not the page copy.
        if (s.held && s.held_idx == arb_bus.idx) begin
            w1 = s.hcw1;
            w2 = s.hcw2;
        end else begin
            w1 = s.page[{arb_bus.idx, 1'b0}];
            w2 = s.page[{arb_bus.idx, 1'b1}];
        end
        zero = w2[LENW-1:0] == 13'h0000;
        ncw1 = s.cw1 + 16'((s.cw2[WORD_BIT] || s.cw2[0]) ? 1 : 0);
        ncw2 = s.cw2 - 16'h0001;
        merged = s.data;
        if (s.cw2[WORD_BIT]) begin
            merged = s.din_s[2];
        end else if (s.cw2[0]) begin
            merged[7:0] = s.din_s[2][7:0];
        end else begin
            merged[15:8] = s.din_s[2][7:0];
        end

        next_s.srq_s[0] = srq_i;
        next_s.srq_s[1] = s.srq_s[0];
        next_s.srq_s[2] = s.srq_s[1];
        next_s.ack_s = {s.ack_s[1:0], io_ack_i};
        next_s.din_s[0] = io_dat_i;
        next_s.din_s[1] = s.din_s[0];
        next_s.din_s[2] = s.din_s[1];
        if (s.srq_s[1] == s.srq_s[2]) begin
            next_s.srq = s.srq_s[2];
        end
        if (s.ack_s[1] == s.ack_s[2]) begin
            next_s.ack = s.ack_s[2];
        end
        next_s.irq = '0;
        next_s.wb_ack = 1'b0;
        if (tick && s.st != S_IDLE) begin
            next_s.step = s.step + 3'h1;
        end
        if (tick && !s.quiet) begin
            next_s.quiet_cnt = s.quiet_cnt + 5'h01;
            next_s.quiet = s.quiet_cnt + 5'h01 == 5'(STOP_US);
        end

        unique case (s.st)
            S_IDLE: begin
                // Burst hold keeps the processor out, so no idle point is needed.
                if (arb_bus.valid && (idle_i || s.hold)) begin
                    start = 1'b1;
                    next_s.idx = arb_bus.idx;
                    next_s.step = 3'h0;
                    next_s.acked = 1'b0;
                    next_s.cw1 = w1;
                    next_s.cw2 = w2;
                    next_s.quiet = 1'b0;
                    next_s.quiet_cnt = 5'h00;
                    if (zero) begin
                        // The request stays up, so this repeats every lim steps.
                        next_s.irq[arb_bus.idx] = 1'b1;
                        next_s.st = S_PAD;
                    end else begin
                        next_s.st = S_READ;
                        next_s.mem_req = 1'b1;
                        next_s.mem_we = 1'b0;
                        next_s.mem_adr = w1;
                        if (w2[BURST_BIT]) begin
                            next_s.hold = 1'b1;
                        end
                    end
                end
            end
            S_READ: begin
                if (mem_ack_i) begin
                    next_s.mem_req = 1'b0;
                    next_s.data = mem_dat_i;
                    next_s.st = S_IO;
                    next_s.io_stb = 1'b1;
                    next_s.io_sel = s.idx;
                    next_s.io_dir = s.cw2[DIR_BIT];
                    if (s.cw2[WORD_BIT]) begin
                        next_s.io_dat = mem_dat_i;
                    end else begin
                        next_s.io_dat = {8'h00, s.cw2[0] ? mem_dat_i[7:0] : mem_dat_i[15:8]};
                    end
                end
            end
            S_IO: begin
                // Timing errors are the controller's to flag; a late ack is simply missed.
                if (s.ack) begin
                    next_s.io_stb = 1'b0;
                    next_s.acked = 1'b1;
                    next_s.st = S_WRITE;
                    if (s.cw2[DIR_BIT]) begin
                        next_s.data = merged;
                        next_s.mem_req = 1'b1;
                        next_s.mem_we = 1'b1;
                        next_s.mem_dat = merged;
                    end
                end else if (s.step >= lim - 3'h1) begin
                    next_s.io_stb = 1'b0;
                    next_s.st = S_WRITE;
                end
            end
            S_WRITE: begin
                if (!s.mem_req || mem_ack_i) begin
                    done = ncw2[LENW-1:0] == 13'h0000 || !s.acked;
                    next_s.mem_req = 1'b0;
                    next_s.mem_we = 1'b0;
                    next_s.cw1 = ncw1;
                    next_s.cw2 = ncw2;
                    next_s.st = S_PAD;
                    if (s.cw2[BURST_BIT] && !done) begin
                        next_s.held = 1'b1;
                        next_s.held_idx = s.idx;
                        next_s.hcw1 = ncw1;
                        next_s.hcw2 = ncw2;
                    end else begin
                        eng_wr = 1'b1;
                        next_s.page[{s.idx, 1'b0}] = ncw1;
                        next_s.page[{s.idx, 1'b1}] = ncw2;
                        if (s.held && s.held_idx == s.idx) begin
                            next_s.held = 1'b0;
                        end
                    end
                    if (done) begin
                        next_s.irq[s.idx] = 1'b1;
                        next_s.hold = 1'b0;
                    end
                end
            end
            S_PAD: begin
                // Leaving on the last tick puts the next start exactly lim steps after this one.
                if (s.step >= lim || (tick && s.step == lim - 3'h1)) begin
                    next_s.st = S_IDLE;
                end
            end
        endcase

        // The engine's write-back wins; a colliding bus cycle waits one clock.
        if (wb_cyc_i && wb_stb_i && !s.wb_ack && !eng_wr) begin
            next_s.wb_ack = 1'b1;
            next_s.wb_dat = 16'h0000;
            if (wb_adr_i[7] == CW_BASE[7]) begin
                next_s.wb_dat = s.page[wb_adr_i[6:2]];
                if (wb_we_i && wb_sel_i[0]) begin
                    next_s.page[wb_adr_i[6:2]][7:0] = wb_dat_i[7:0];
                end
                if (wb_we_i && wb_sel_i[1]) begin
                    next_s.page[wb_adr_i[6:2]][15:8] = wb_dat_i[15:8];
                end
            end else if (wb_adr_i == STAT_OFF) begin
                next_s.wb_dat = {7'h00, s.quiet, s.hold, s.held, s.st != S_IDLE, 1'b0, s.idx};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.page <= {32{CW_RST}};
        end else begin
            s <= next_s;
        end
    end

    assign wb_dat_o = {16'h0000, s.wb_dat};
    assign wb_ack_o = s.wb_ack;
    assign mem_req_o = s.mem_req;
    assign mem_we_o = s.mem_we;
    assign mem_adr_o = s.mem_adr;
    assign mem_dat_o = s.mem_dat;
    assign hold_o = s.hold;
    assign level_irq_o = s.irq;
    assign stop_ok_o = s.quiet;
    assign io_stb_o = s.io_stb;
    assign io_dir_o = s.io_dir;
    assign io_sel_o = s.io_sel;
    assign io_dat_o = s.io_dat;

    // Cycles spent away from idle, read only by the checks below.
    logic [12:0] run_cnt;
    always_ff @(posedge clk_i) begin
        if (rst_i || s.st == S_IDLE) begin
            run_cnt <= 13'h0000;
        end else begin
            run_cnt <= run_cnt + 13'h0001;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    idle_wait_a: assert property (s.st == S_IDLE && s.srq == 16'h0000 |=> s.st == S_IDLE)
        else $error("channel left idle without a request");
    zero_len_a: assert property (start && zero |=> level_irq_o != 16'h0000 && !mem_req_o ##1 !io_stb_o)
        else $error("zero length did not interrupt cleanly");
    try_xfer_a: assert property (start && !zero |=> mem_req_o && !mem_we_o && s.st == S_READ)
        else $error("nonzero length did not start a read");
    pace_a: assert property (s.st == S_PAD && next_s.st == S_IDLE
        |-> run_cnt >= 13'(lim * TICK_CYC - TICK_LEAD))
        else $error("transfer finished early");
    prio_a: assert property (arb_bus.valid |-> (s.srq & ((16'h0001 << arb_bus.idx) - 16'h0001)) == 16'h0000)
        else $error("lower priority controller granted");
    burst_hold_a: assert property (start && !zero && w2[BURST_BIT] |=> hold_o [*3])
        else $error("burst did not hold the processor");
    count_a: assert property (s.st == S_WRITE && next_s.st == S_PAD |=> s.cw2 == $past(s.cw2) - 16'h0001)
        else $error("length not counted down");
    no_ack_a: assert property (s.st == S_WRITE && next_s.st == S_PAD && !s.acked |=> level_irq_o[s.idx] && !hold_o)
        else $error("missing acknowledge did not end record");
    stop_gap_a: assert property ($rose(stop_ok_o) |-> s.quiet_cnt == 5'(STOP_US))
        else $error("stop allowed too soon");
    reset_a: assert property ($fell(rst_i) |-> !s.held && !hold_o && s.st == S_IDLE)
        else $error("reset left burst state");

    burst_c: cover property (start && w2[BURST_BIT] ##[1:1000] !hold_o);
    zero_c: cover property (start && zero);
    no_ack_c: cover property (s.st == S_WRITE && !s.acked && next_s.st == S_PAD);
endmodule
`default_nettype wire

//--- testbench/mbtc_dev_model.sv
// Purpose: Device controllers on the shared I/O bus, seen from the pins.
// Assumes: One data transfer per strobe; the selected controller answers.
// Notes: The bench arms a controller with a request count and an ack limit.
`timescale 1ns/1ns
`default_nettype none
module mbtc_dev_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Shared I/O bus
    input wire logic io_stb_i,
    input wire logic [3:0] io_sel_i,
    output logic [15:0] srq_o,
    output logic io_ack_o,
    output logic [15:0] io_dat_o
);
    int left [16];
    int gap [16];
    int seq;
    int ack_lim;
    logic stb_d;
    logic live;

    initial begin
        foreach (left[i]) left[i] = 0;
        foreach (gap[i]) gap[i] = 0;
        srq_o = 16'h0000;
        io_ack_o = 1'b0;
        io_dat_o = 16'h0000;
        stb_d = 1'b0;
        live = 1'b0;
        seq = 1;
        ack_lim = 0;
    end

    // Requests only flow once the controller is started; zero stops it.
    task automatic arm(input int i, input int n, input int lim);
        left[i] = n;
        ack_lim = lim;
        seq = 1;
    endtask

    always @(posedge clk_i) begin
        stb_d <= io_stb_i;
        for (int i = 0; i < 16; i++) begin
            srq_o[i] <= !rst_i && left[i] > 0 && gap[i] == 0;
            if (gap[i] > 0) gap[i]--;
        end
        if (io_stb_i && !stb_d) begin
            left[io_sel_i]--;
            gap[io_sel_i] = 50;
            live = seq <= ack_lim;
        end
        // Data is held for the whole strobe while acks are live; otherwise the bus inverts its last value every clock.
        if (io_stb_i && live) begin
            io_ack_o <= 1'b1;
            io_dat_o <= {8'hD0, seq[7:0]};
        end else begin
            io_ack_o <= 1'b0;
            io_dat_o <= ~io_dat_o;
        end
        if (!io_stb_i && stb_d && live) seq++;
    end
endmodule
`default_nettype wire

//--- testbench/tb_mbtc_chan.sv
// Purpose: Self-checking bench for the block transfer channel.
// Assumes: Processor idle unless a test holds it busy; memory answers one cycle after a request.
// Notes: Monitors record strobe times, selects, data and level pulses.
`timescale 1ns/1ns
`default_nettype none
module tb_mbtc_chan;
    import mbtc_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mem_req_o, mem_we_o, mem_ack_i;
    logic hold_o, stop_ok_o, io_ack_i, io_stb_o, io_dir_o, stb_q, req_q, idle_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i, io_sel_o;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [15:0] mem_adr_o, mem_dat_o, mem_dat_i, io_dat_i, io_dat_o, srq_i, level_irq_o, rd;
    logic [15:0] mem [512];
    int err_total, comparisons, cyc, mreq_n;
    int irq_n [16];
    int stb_t [$];
    logic [3:0] stb_s [$];
    logic [15:0] stb_v [$];

    mbtc_chan mbtc_chan_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .mem_req_o, .mem_we_o, .mem_adr_o, .mem_dat_o, .mem_dat_i,
        .mem_ack_i, .idle_i, .hold_o, .level_irq_o, .stop_ok_o, .srq_i, .io_ack_i, .io_dat_i,
        .io_stb_o, .io_dir_o, .io_sel_o, .io_dat_o);
    mbtc_dev_model mbtc_dev_model_i (.clk_i, .rst_i, .io_stb_i(io_stb_o), .io_sel_i(io_sel_o),
        .srq_o(srq_i), .io_ack_o(io_ack_i), .io_dat_o(io_dat_i));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc++;
        mem_ack_i <= mem_req_o && !mem_ack_i;
        if (mem_req_o && !mem_ack_i) begin
            mem_dat_i <= mem[mem_adr_o[8:0]];
            if (mem_we_o) mem[mem_adr_o[8:0]] <= mem_dat_o;
        end
        if (mem_req_o && !req_q) mreq_n++;
        req_q <= mem_req_o;
        stb_q <= io_stb_o;
        if (io_stb_o && !stb_q) begin
            stb_t.push_back(cyc);
            stb_s.push_back(io_sel_o);
            stb_v.push_back(io_dat_o);
        end
        for (int i = 0; i < 16; i++) if (level_irq_o[i] === 1'b1) irq_n[i]++;
    end

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tmo;
        chk(32'h0, 32'h1);
        finish_test();
    endtask

    task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'h3;
        wb_dat_i <= {16'h0000, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1) tmo();
        q = wb_dat_o[15:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic set_cw(input logic [7:0] a, input logic [15:0] w1, input logic [15:0] w2);
        wb(1'b1, a, w1, rd);
        wb(1'b1, a + 8'h04, w2, rd);
        stb_t.delete();
        stb_s.delete();
        stb_v.delete();
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        wb(1'b0, a, 16'h0000, rd);
        chk(rd, e);
    endtask

    // Waits settle one step past the edge so the monitors have already run.
    task automatic wait_irq(input int i, input int n);
        int k;
        for (k = 0; k < 20000 && irq_n[i] < n; k++) @(posedge clk_i) #1;
        if (irq_n[i] < n) tmo();
    endtask

    task automatic wait_stb(input int n);
        int k;
        for (k = 0; k < 20000 && stb_t.size() < n; k++) @(posedge clk_i) #1;
        if (stb_t.size() < n) tmo();
    endtask

    task automatic t_idle;
        rd_chk(8'h1C, 16'h0000);
        set_cw(8'h18, 16'h0030, 16'h8005);
        repeat (300) @(posedge clk_i);
        chk(mreq_n, 0);
        rd_chk(8'h18, 16'h0030);
        rd_chk(8'hF0, 16'h0000);
        $display("test idle done");
    endtask

    task automatic t_zero;
        set_cw(8'h28, 16'h0060, 16'h8000);
        idle_i <= 1'b0;
        mbtc_dev_model_i.arm(5, 1, 99);
        repeat (20) @(posedge clk_i);
        chk(irq_n[5], 0);
        idle_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1 chk(irq_n[5], 1);
        wait_irq(5, 1);
        repeat (600) @(posedge clk_i);
        chk(irq_n[5], 2);
        chk(srq_i[5], 1'b1);
        chk(mreq_n + stb_t.size(), 0);
        mbtc_dev_model_i.arm(5, 0, 99);
        $display("test zero done");
    endtask

    task automatic t_burst;
        mem[9'h020] = 16'h1234;
        mem[9'h021] = 16'h5678;
        set_cw(8'h00, 16'h0020, 16'h6002);
        mbtc_dev_model_i.arm(0, 2, 99);
        wait_stb(1);
        chk(hold_o, 1'b1);
        wait_irq(0, 1);
        chk(stb_t[1] - stb_t[0], 300);
        chk(stb_v[0], 16'h1234);
        chk(stb_v[1], 16'h5678);
        repeat (3) @(posedge clk_i);
        chk(hold_o, 1'b0);
        rd_chk(8'h00, 16'h0022);
        rd_chk(8'h04, 16'h6000);
        $display("test burst done");
    endtask

    task automatic t_prio;
        set_cw(8'h10, 16'h0050, 16'hA002);
        wb(1'b1, 8'h08, 16'h0040, rd);
        wb(1'b1, 8'h0C, 16'hA002, rd);
        mbtc_dev_model_i.arm(2, 2, 99);
        mbtc_dev_model_i.arm(1, 2, 99);
        wait_irq(2, 1);
        chk({stb_s[0], stb_s[1], stb_s[2], stb_s[3]}, 16'h1122);
        chk(stb_t[3] - stb_t[2], 500);
        chk(mem[9'h040], 16'hD001);
        chk(mem[9'h041], 16'hD002);
        chk(mem[9'h051], 16'hD004);
        chk(irq_n[1], 1);
        rd_chk(8'h08, 16'h0042);
        rd_chk(8'h0C, 16'hA000);
        $display("test priority done");
    endtask

    task automatic t_nack;
        mem[9'h100] = 16'hEE00;
        set_cw(8'h38, 16'h0100, 16'h800F);
        mbtc_dev_model_i.arm(7, 11, 10);
        wait_irq(7, 1);
        chk(stop_ok_o, 1'b0);
        chk(stb_t.size(), 11);
        chk(mem[9'h100], 16'hEE01);
        chk(mem[9'h101], 16'h0203);
        chk(mem[9'h104], 16'h0809);
        rd_chk(8'h38, 16'h0106);
        rd_chk(8'h3C, 16'h8004);
        repeat (2600) @(posedge clk_i);
        chk(stop_ok_o, 1'b1);
        rd_chk(8'h80, 16'h0107);
        $display("test unacknowledged done");
    endtask

    // A reset in the middle of a burst block must drop the held words.
    task automatic t_reset;
        set_cw(8'h00, 16'h0020, 16'h4002);
        mbtc_dev_model_i.arm(0, 2, 99);
        wait_stb(1);
        chk(stb_v[0], 16'h0012);
        repeat (20) @(posedge clk_i);
        rd_chk(8'h80, 16'h00E0);
        rst_i <= 1'b1;
        mbtc_dev_model_i.arm(0, 0, 99);
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(hold_o, 1'b0);
        rd_chk(8'h80, 16'h0000);
        rd_chk(8'h04, 16'h0000);
        $display("test reset done");
    endtask

    initial begin
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        mem_ack_i = 1'b0;
        mem_dat_i = 16'h0000;
        idle_i = 1'b1;
        stb_q = 1'b0;
        req_q = 1'b0;
        foreach (mem[i]) mem[i] = 16'h0000;
        foreach (irq_n[i]) irq_n[i] = 0;
        err_total = 0;
        comparisons = 0;
        cyc = 0;
        mreq_n = 0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        t_idle();
        t_zero();
        t_burst();
        t_prio();
        t_nack();
        t_reset();
        finish_test();
    end
endmodule
`default_nettype wire
